/* File: src/wdit_pkg.sv */
// Package for the watchdog and interval timer block.
// Assumes a byte-wide register port and a single oscillator clock domain.
package wdit_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] WDIT_ADDR_WD_CTRL  = 8'hDC;
   localparam logic [7:0] WDIT_ADDR_WD_COUNT = 8'hDD;
   localparam logic [7:0] WDIT_ADDR_IT_CTRL  = 8'hD0;
   localparam logic [7:0] WDIT_ADDR_IT_MATCH = 8'hD1;
   localparam logic [7:0] WDIT_ADDR_IT_COUNT = 8'hD2;
   localparam logic [7:0] WDIT_ADDR_STATUS   = 8'hD3;

   // ----------------------------------------------------------------
   // Reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] WDIT_WD_CTRL_RST  = 8'h00;
   localparam logic [7:0] WDIT_IT_CTRL_RST  = 8'h00;
   localparam logic [7:0] WDIT_IT_MATCH_RST = 8'hFF;
   localparam logic [3:0] WDIT_WD_KEY       = 4'hA;
   localparam int WDIT_WD_CLR_BIT  = 1;
   localparam int WDIT_PRE_CLR_BIT = 0;
   localparam int WDIT_IT_CLR_BIT  = 3;
   localparam int WDIT_IT_IE_BIT   = 1;
   localparam int WDIT_IT_PND_BIT  = 0;
   localparam int WDIT_STAB_BIT    = 4;

   // ----------------------------------------------------------------
   // Prescaler taps (divisor = 2**(tap+1), carry out of that stage)
   // ----------------------------------------------------------------
   localparam int WDIT_PRE_W     = 12;
   localparam int WDIT_TAP_4096  = 11;
   localparam int WDIT_TAP_1024  = 9;
   localparam int WDIT_TAP_256   = 7;
   localparam int WDIT_TAP_128   = 6;
   localparam int WDIT_TAP_8     = 2;

   // Watchdog clock select codes
   typedef enum logic [1:0] {
      WDIT_WSEL_4096 = 2'b00,
      WDIT_WSEL_1024 = 2'b01,
      WDIT_WSEL_128  = 2'b10,
      WDIT_WSEL_BAD  = 2'b11
   } wdit_wsel_e;

   // Stabilisation sequencer states
   typedef enum logic [1:0] {
      WDIT_ST_RUN     = 2'b00,
      WDIT_ST_STAB_RS = 2'b01,
      WDIT_ST_STAB_WK = 2'b10
   } wdit_state_e;
endpackage

/* File: src/wdit_top.sv */
// Watchdog timer plus 8-bit interval timer with match interrupt.
// Assumes the register master obeys one-cycle strobes and that stop entry
// and wake requests arrive from pins outside this clock domain.
//
// Notes on behaviour
// - Watchdog count clock is oscillator divided by 4096, 1024 or 128.
// - Select bits 3:2: 00 /4096, 01 /1024, 10 /128, 11 invalid.
// - Reset loads watchdog control with zero: watchdog on, divide by 4096.
// - Watchdog reset disabled only while control bits 7:4 hold 1010.
// - Writing one to control bit 1 clears the watchdog counter.
// - Writing one to control bit 0 clears the shared prescaler.
// - Watchdog count read-only at DD, control read/write at DC.
// - Enabled watchdog resets system when counter overflows out of bit 7.
// - In stop, reset or wake restarts oscillator and stabilisation count.
// - Stabilisation counts at /4096 after reset, selected rate after wake.
// - Counter bit 4 set ends stabilisation and releases CPU clock.
// - Interval counter clock: oscillator /4096, /256, /8 or undivided.
// - Reset clears interval control: interval mode, /4096, interrupt off.
// - Writing one to interval control bit 3 clears the interval counter.
// - Match asserted when interval counter equals the match value.
// - Each match sets the pending flag, zeroes counter, keeps counting.
// - Interval control holds match interrupt enable and pending bits.
// - Pending flag is interval control bit 0, set on match.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
module wdit_top
   import wdit_pkg::*;
#(
   parameter int WDIT_STAB_LEN = 16
) (
   // Clock and reset
   input  wire logic       CLK,
   input  wire logic       RST_N,
   // Register port
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   // Power control pins
   input  wire logic       STOP_REQ,
   input  wire logic       WAKE_IRQ,
   // Outputs to the system
   output logic            SYS_RESET,
   output logic            CPU_CLK_EN,
   output logic            STAB_DONE,
   output logic            INTERVAL_MATCH_INTERRUPT
);
   import wdit_pkg::*;

   initial begin
      if (WDIT_STAB_LEN != (1 << WDIT_STAB_BIT)) begin
         $error("WDIT_STAB_LEN must equal the weight of the stabilisation bit");
      end
   end

   // ----------------------------------------------------------------
   // Reset release and pin synchronisers
   // ----------------------------------------------------------------
   logic rst_meta_reg, rst_n_reg;
   logic stop_meta_reg, stop_reg, wake_meta_reg, wake_reg, wake_prev_reg;

   // Reset release through two stages so no flop sees a runt release
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   // Pin inputs are asynchronous
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         stop_meta_reg <= 1'b0;
         stop_reg      <= 1'b0;
         wake_meta_reg <= 1'b0;
         wake_reg      <= 1'b0;
         wake_prev_reg <= 1'b0;
      end else begin
         stop_meta_reg <= STOP_REQ;
         stop_reg      <= stop_meta_reg;
         wake_meta_reg <= WAKE_IRQ;
         wake_reg      <= wake_meta_reg;
         wake_prev_reg <= wake_reg;
      end
   end

   // ----------------------------------------------------------------
   // Registers and decode
   // ----------------------------------------------------------------
   logic [7:0] wd_ctrl_reg, wd_cnt_reg, it_ctrl_reg, it_match_reg, it_cnt_reg;
   logic [WDIT_PRE_W-1:0] pre_reg, pre_next;
   wdit_state_e state_reg;
   logic wr_wdc, wr_itc, wd_tick, it_tick, wd_en, match, in_stop_reg;

   // Carry out of the selected prescaler stage marks one divided clock; a full
   // divisor period follows a prescaler clear, so wake waits are not cut short
   function automatic logic tap_rise(input logic [WDIT_PRE_W-1:0] cur,
                                     input logic [WDIT_PRE_W-1:0] nxt,
                                     input int tap);
      logic [WDIT_PRE_W-1:0] mask;
      mask     = (WDIT_PRE_W'(1) << (tap + 1)) - 1'b1;
      tap_rise = ((cur & mask) == mask) && (nxt == cur + 1'b1);
   endfunction

   assign wr_wdc = WR && (ADDR == WDIT_ADDR_WD_CTRL);
   assign wr_itc = WR && (ADDR == WDIT_ADDR_IT_CTRL);
   assign wd_en  = (wd_ctrl_reg[7:4] != WDIT_WD_KEY);

   // Shared prescaler; runs free except while the CPU is stopped
   always_comb begin
      pre_next = pre_reg + 1'b1;
      if (wr_wdc && WDATA[WDIT_PRE_CLR_BIT]) begin
         pre_next = '0;
      end
   end

   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         pre_reg <= '0;
      end else if (in_stop_reg) begin
         pre_reg <= '0;
      end else begin
         pre_reg <= pre_next;
      end
   end

   // Watchdog tick selection, reset stabilisation forces /4096
   always_comb begin
      wd_tick = 1'b0;
      if (state_reg == WDIT_ST_STAB_RS) begin
         wd_tick = tap_rise(pre_reg, pre_next, WDIT_TAP_4096);
      end else begin
         unique case (wd_ctrl_reg[3:2])
            WDIT_WSEL_4096: wd_tick = tap_rise(pre_reg, pre_next, WDIT_TAP_4096);
            WDIT_WSEL_1024: wd_tick = tap_rise(pre_reg, pre_next, WDIT_TAP_1024);
            WDIT_WSEL_128:  wd_tick = tap_rise(pre_reg, pre_next, WDIT_TAP_128);
            default:        wd_tick = 1'b0; // Invalid code stalls the count
         endcase
      end
   end

   // Interval tick selection
   always_comb begin
      unique case (it_ctrl_reg[5:4])
         2'b00:   it_tick = tap_rise(pre_reg, pre_next, WDIT_TAP_4096);
         2'b01:   it_tick = tap_rise(pre_reg, pre_next, WDIT_TAP_256);
         2'b10:   it_tick = tap_rise(pre_reg, pre_next, WDIT_TAP_8);
         default: it_tick = 1'b1;
      endcase
   end

   // ----------------------------------------------------------------
   // Watchdog control and counter
   // ----------------------------------------------------------------
   // Control write; clear bits self-clear so they read back zero
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         wd_ctrl_reg <= WDIT_WD_CTRL_RST;
      end else if (wr_wdc) begin
         wd_ctrl_reg <= {WDATA[7:2], 2'b00};
      end
   end

   // Stop and stabilisation sequencer
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         state_reg   <= WDIT_ST_STAB_RS;
         in_stop_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            WDIT_ST_RUN: begin
               if (!in_stop_reg && stop_reg) begin
                  in_stop_reg <= 1'b1;
               end else if (in_stop_reg && wake_reg && !wake_prev_reg) begin
                  in_stop_reg <= 1'b0;
                  state_reg   <= WDIT_ST_STAB_WK;
               end
            end
            WDIT_ST_STAB_RS, WDIT_ST_STAB_WK: begin
               if (wd_cnt_reg[WDIT_STAB_BIT]) begin
                  state_reg <= WDIT_ST_RUN;
               end
            end
            default: state_reg <= WDIT_ST_RUN;
         endcase
      end
   end

   // Watchdog counter; wake restarts it from zero
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         wd_cnt_reg <= 8'h00;
      end else if (state_reg == WDIT_ST_RUN && in_stop_reg) begin
         wd_cnt_reg <= 8'h00;
      end else if (wr_wdc && WDATA[WDIT_WD_CLR_BIT]) begin
         wd_cnt_reg <= 8'h00;
      end else if (wd_tick) begin
         wd_cnt_reg <= wd_cnt_reg + 8'h01;
      end
   end

   // System reset pulse on bit 7 overflow; it lasts one cycle
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         SYS_RESET <= 1'b0;
      end else begin
         SYS_RESET <= wd_en && (state_reg == WDIT_ST_RUN) && wd_tick
                      && (wd_cnt_reg == 8'hFF)
                      && !(wr_wdc && WDATA[WDIT_WD_CLR_BIT]);
      end
   end

   // CPU clock gate and done level
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         CPU_CLK_EN <= 1'b0;
         STAB_DONE  <= 1'b0;
      end else begin
         CPU_CLK_EN <= (state_reg == WDIT_ST_RUN) && !in_stop_reg;
         STAB_DONE  <= (state_reg == WDIT_ST_RUN);
      end
   end

   // ----------------------------------------------------------------
   // Interval timer
   // ----------------------------------------------------------------
   assign match = it_tick && !in_stop_reg && (it_cnt_reg == it_match_reg);

   // Control: bits 7:4 config, bit 3 clear strobe, bit 1 enable, bit 0 pending
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         it_ctrl_reg <= WDIT_IT_CTRL_RST;
      end else begin
         if (wr_itc) begin
            it_ctrl_reg[7:1] <= {WDATA[7:4], 1'b0, WDATA[2:1]};
         end
         // Set wins over a software clear in the same cycle
         if (match) begin
            it_ctrl_reg[WDIT_IT_PND_BIT] <= 1'b1;
         end else if (wr_itc && !WDATA[WDIT_IT_PND_BIT]) begin
            it_ctrl_reg[WDIT_IT_PND_BIT] <= 1'b0;
         end
      end
   end

   // Match value register
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         it_match_reg <= WDIT_IT_MATCH_RST;
      end else if (WR && ADDR == WDIT_ADDR_IT_MATCH) begin
         it_match_reg <= WDATA;
      end
   end

   // Interval counter; match zeroes and counting resumes
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         it_cnt_reg <= 8'h00;
      end else if (wr_itc && WDATA[WDIT_IT_CLR_BIT]) begin
         it_cnt_reg <= 8'h00;
      end else if (match) begin
         it_cnt_reg <= 8'h00;
      end else if (it_tick && !in_stop_reg) begin
         it_cnt_reg <= it_cnt_reg + 8'h01;
      end
   end

   // Interrupt request
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         INTERVAL_MATCH_INTERRUPT <= 1'b0;
      end else begin
         INTERVAL_MATCH_INTERRUPT <= it_ctrl_reg[WDIT_IT_PND_BIT]
                                     && it_ctrl_reg[WDIT_IT_IE_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Read port; unmapped addresses return zero
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         RDATA <= 8'h00;
      end else if (RD) begin
         unique case (ADDR)
            WDIT_ADDR_WD_CTRL:  RDATA <= wd_ctrl_reg;
            WDIT_ADDR_WD_COUNT: RDATA <= wd_cnt_reg;
            WDIT_ADDR_IT_CTRL:  RDATA <= it_ctrl_reg;
            WDIT_ADDR_IT_MATCH: RDATA <= it_match_reg;
            WDIT_ADDR_IT_COUNT: RDATA <= it_cnt_reg;
            WDIT_ADDR_STATUS:   RDATA <= {5'h00, in_stop_reg, state_reg};
            default:            RDATA <= 8'h00;
         endcase
      end else begin
         RDATA <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!rst_n_reg);

   key_disables_a: assert property (!wd_en |=> !SYS_RESET)
      else $error("watchdog reset while disabled");
   ovf_reset_a: assert property (wd_en && state_reg == WDIT_ST_RUN && wd_tick
      && wd_cnt_reg == 8'hFF && !wr_wdc |=> SYS_RESET)
      else $error("overflow missed reset");
   wd_clear_a: assert property (wr_wdc && WDATA[1] |=> wd_cnt_reg == 8'h00)
      else $error("watchdog count not cleared");
   pre_clear_a: assert property (wr_wdc && WDATA[0] && !in_stop_reg |=> pre_reg == '0)
      else $error("prescaler not cleared");
   stab_end_a: assert property (state_reg != WDIT_ST_RUN && wd_cnt_reg[4]
      |=> state_reg == WDIT_ST_RUN ##1 STAB_DONE)
      else $error("stabilisation did not end");
   it_clear_a: assert property (wr_itc && WDATA[3] |=> it_cnt_reg == 8'h00)
      else $error("interval count not cleared");
   match_pend_a: assert property (match |=> it_ctrl_reg[0] && it_cnt_reg == 8'h00)
      else $error("match did not set pending");
   pend_hold_a: assert property (it_ctrl_reg[0] && !(wr_itc && !WDATA[0])
      |=> it_ctrl_reg[0])
      else $error("pending lost");
   irq_gate_a: assert property (INTERVAL_MATCH_INTERRUPT
      == ($past(it_ctrl_reg[0]) && $past(it_ctrl_reg[1])))
      else $error("interrupt request differs from pending and enable");
   ie_mask_a: assert property (!it_ctrl_reg[WDIT_IT_IE_BIT]
      |=> !INTERVAL_MATCH_INTERRUPT)
      else $error("interrupt while disabled");

   // CPU clock gating, stabilisation rate and the read-only count
   stab_gate_a: assert property (state_reg != WDIT_ST_RUN
      |=> !CPU_CLK_EN && !STAB_DONE)
      else $error("CPU clock released during stabilisation");
   stop_gate_a: assert property (in_stop_reg |=> !CPU_CLK_EN)
      else $error("CPU clock running in stop");
   stab_rate_a: assert property (state_reg == WDIT_ST_STAB_RS && wd_tick |-> &pre_reg)
      else $error("reset stabilisation not at divide by 4096");
   ro_count_a: assert property (WR && ADDR == WDIT_ADDR_WD_COUNT && !wd_tick
      && !in_stop_reg |=> $stable(wd_cnt_reg))
      else $error("read-only count written");

   match_c:   cover property (match ##1 INTERVAL_MATCH_INTERRUPT);
   wdog_c:    cover property (SYS_RESET);
   wake_c:    cover property (state_reg == WDIT_ST_STAB_WK ##1 state_reg == WDIT_ST_RUN);
   key_off_c: cover property (!wd_en);
   stop_c:    cover property (in_stop_reg ##1 !in_stop_reg);
endmodule

/* File: dv/wdit_top_test.sv */
// Self-checking bench for the watchdog and interval timer block.
// Assumes the register port and pins of wdit_top; drives all inputs itself.
`timescale 1ns/10ps
module wdit_top_test;
   import wdit_pkg::*;
   // ----------------------------------------------------------------
   // Stimulus signals and counters
   // ----------------------------------------------------------------
   logic       clk;
   logic       rst_n;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       stop_req;
   logic       wake_irq;
   logic       sys_reset;
   logic       cpu_clk_en;
   logic       stab_done;
   logic       match_irq;
   int         failures;
   int         n_checks;
   int         cyc;
   int         n_rst;
   int         t0;
   int         n;
   logic [7:0] d;
   int         divs [3] = '{1, 8, 256};
   logic [1:0] codes [3] = '{2'b11, 2'b10, 2'b01};

   wdit_top i_wdit_top (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .STOP_REQ(stop_req), .WAKE_IRQ(wake_irq),
      .SYS_RESET(sys_reset), .CPU_CLK_EN(cpu_clk_en), .STAB_DONE(stab_done),
      .INTERVAL_MATCH_INTERRUPT(match_irq));

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Cycle stamp and count of watchdog reset pulses
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (sys_reset === 1'b1) n_rst <= n_rst + 1;
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 v = rdata;
   endtask

   function automatic logic pick(input int w);
      case (w)
         0: pick = cpu_clk_en;
         1: pick = sys_reset;
         2: pick = match_irq;
         default: pick = ~cpu_clk_en;
      endcase
   endfunction

   // Bounded wait; one-cycle pulses are seen since every cycle is sampled
   task automatic wait_for(input int w, input int lim, output int cnt);
      cnt = 0;
      do begin
         @(posedge clk);
         #1 cnt++;
      end while (pick(w) !== 1'b1 && cnt < lim);
   endtask

   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Watchdog sized above the longest expected run
   initial begin
      repeat (130000) @(posedge clk);
      failures++;
      give_verdict;
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {failures, n_checks, cyc, n_rst} = '0;
      {addr, wdata, wr, rd, stop_req, wake_irq} = '0;
      rst_n = 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t0 = cyc + 1;
      repeat (3) @(posedge clk);
      // Reset values, unmapped place and read-only counters
      rd_reg(WDIT_ADDR_WD_CTRL, d);  check(d, 8'h00);
      rd_reg(WDIT_ADDR_IT_CTRL, d);  check(d, 8'h00);
      rd_reg(WDIT_ADDR_IT_MATCH, d); check(d, 8'hFF);
      rd_reg(8'h40, d);              check(d, 8'h00);
      wr_reg(WDIT_ADDR_WD_COUNT, 8'hFF);
      rd_reg(WDIT_ADDR_WD_COUNT, d); check(d, 8'h00);
      wr_reg(WDIT_ADDR_IT_COUNT, 8'hFF);
      rd_reg(WDIT_ADDR_IT_COUNT, d); check(d, 8'h00);
      check(cpu_clk_en, 1'b0);
      // Reset stabilisation: 16 ticks of the divide-by-4096 clock
      wait_for(0, 70000, n);
      n = cyc - t0;
      check(16'(n >= 65536 && n <= 65700), 16'h1);
      check(stab_done, 1'b1);
      rd_reg(WDIT_ADDR_WD_COUNT, d); check(d, 8'h10);
      // Counter clear, clear bits read back as zero
      wr_reg(WDIT_ADDR_WD_CTRL, 8'h02);
      rd_reg(WDIT_ADDR_WD_COUNT, d); check(d, 8'h00);
      rd_reg(WDIT_ADDR_WD_CTRL, d);  check(d, 8'h00);
      // Interval clock rates, with the shared prescaler cleared first
      wr_reg(WDIT_ADDR_IT_MATCH, 8'hFF);
      for (int i = 0; i < 3; i++) begin
         wr_reg(WDIT_ADDR_WD_CTRL, 8'h01);
         wr_reg(WDIT_ADDR_IT_CTRL, {2'b00, codes[i], 4'h8});
         repeat (16 * divs[i]) @(posedge clk);
         rd_reg(WDIT_ADDR_IT_COUNT, d);
         check(16'(d >= 15 && d <= 17), 16'h1);
      end
      wr_reg(WDIT_ADDR_IT_CTRL, 8'h28);
      rd_reg(WDIT_ADDR_IT_COUNT, d); check(16'(d <= 1), 16'h1);
      // Match at 2 on the undivided clock, interrupt enabled
      wr_reg(WDIT_ADDR_IT_MATCH, 8'h02);
      wr_reg(WDIT_ADDR_IT_CTRL, 8'h3A);
      wait_for(2, 20, n); check(match_irq, 1'b1);
      rd_reg(WDIT_ADDR_IT_CTRL, d); check(d & 8'h33, 8'h33);
      repeat (4) begin
         rd_reg(WDIT_ADDR_IT_COUNT, d); check(16'(d <= 2), 16'h1);
      end
      // Pending bit: one keeps it, enable gates the request, zero clears it
      wr_reg(WDIT_ADDR_IT_MATCH, 8'hFF);
      wr_reg(WDIT_ADDR_IT_CTRL, 8'h0B);
      rd_reg(WDIT_ADDR_IT_CTRL, d); check(d, 8'h03);
      check(match_irq, 1'b1);
      wr_reg(WDIT_ADDR_IT_CTRL, 8'h01);
      repeat (2) @(posedge clk);
      #1 check(match_irq, 1'b0);
      rd_reg(WDIT_ADDR_IT_CTRL, d); check(d, 8'h01);
      wr_reg(WDIT_ADDR_IT_CTRL, 8'h00);
      rd_reg(WDIT_ADDR_IT_CTRL, d); check(d, 8'h00);
      check(match_irq, 1'b0);
      // Stop, then wake: stabilisation at the selected divide-by-128
      wr_reg(WDIT_ADDR_WD_CTRL, 8'h08);
      stop_req <= 1'b1;
      wait_for(3, 10, n); check(cpu_clk_en, 1'b0);
      stop_req <= 1'b0;
      repeat (20) @(posedge clk);
      wake_irq <= 1'b1;
      t0 = cyc + 1;
      wait_for(0, 3000, n);
      n = cyc - t0;
      check(16'(n >= 2040 && n <= 2200), 16'h1);
      wake_irq <= 1'b0;
      rd_reg(WDIT_ADDR_WD_COUNT, d); check(d, 8'h10);
      check(16'(n_rst), 16'h0);
      // Let the enabled watchdog overflow out of bit 7
      rd_reg(WDIT_ADDR_WD_COUNT, d);
      t0 = cyc;
      wait_for(1, 33000, n);
      n = cyc - t0;
      check(sys_reset, 1'b1);
      check(16'(n >= (255 - d) * 128 && n <= (256 - d) * 128 + 16), 16'h1);
      // Key pattern turns the watchdog off; exactly one reset pulse so far
      wr_reg(WDIT_ADDR_WD_CTRL, 8'hA8);
      rd_reg(WDIT_ADDR_WD_CTRL, d); check(d, 8'hA8);
      check(16'(n_rst), 16'h1);
      give_verdict;
   end
endmodule
